// >>> hdl/sltm_pkg.sv
// Shared constants for the serial link test monitor and its transmitter.
package sltm_pkg;

  // ----------------------------------------------------------------------
  // Link geometry and bus
  // ----------------------------------------------------------------------
  localparam int NUM_LANES = 8;
  localparam int WB_ADR_W = 14;

  // ----------------------------------------------------------------------
  // Device register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [11:0] REG_LINK_SELECT = 12'h300;
  localparam logic [11:0] REG_LANE_PRBS_ENABLE = 12'h315;
  localparam logic [11:0] REG_PRBS_TEST_CONTROL = 12'h316;
  localparam logic [11:0] REG_PRBS_THRESHOLD_LOW = 12'h317;
  localparam logic [11:0] REG_PRBS_THRESHOLD_MID = 12'h318;
  localparam logic [11:0] REG_PRBS_THRESHOLD_HIGH = 12'h319;
  localparam logic [11:0] REG_PRBS_ERROR_COUNT_LOW = 12'h31a;
  localparam logic [11:0] REG_PRBS_ERROR_COUNT_MID = 12'h31b;
  localparam logic [11:0] REG_PRBS_ERROR_COUNT_HIGH = 12'h31c;
  localparam logic [11:0] REG_LANE_PRBS_PASS = 12'h31d;
  localparam logic [11:0] REG_SAMPLE_TEST_CONTROL = 12'h32c;
  localparam logic [11:0] REG_EXPECTED_SAMPLE_LOW = 12'h32d;
  localparam logic [11:0] REG_EXPECTED_SAMPLE_HIGH = 12'h32e;
  localparam logic [11:0] REG_SAMPLE_TEST_RESULT = 12'h32f;
  localparam logic [11:0] REG_ERROR_COUNTER = 12'h46b;
  localparam logic [11:0] REG_CODE_GROUP_SYNC_STATUS = 12'h470;
  localparam logic [11:0] REG_LANE_INIT_SYNC_STATUS = 12'h473;
  localparam logic [11:0] REG_LINK_TEST_OPTIONS = 12'h477;
  localparam logic [11:0] REG_ERROR_THRESHOLD = 12'h47c;
  localparam logic [11:0] REG_LANE_ENABLE = 12'h47d;
  localparam logic [11:0] REG_LINK_ENABLE = 12'h3f0;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LINK_SEL_BIT = 2;
  localparam int PRBS_CLEAR_BIT = 0;
  localparam int PRBS_RUN_BIT = 1;
  localparam int PRBS_PAT_LSB = 2;
  localparam int PRBS_LANE_LSB = 4;
  localparam int SAMPLE_EN_BIT = 0;
  localparam int SAMPLE_CLEAR_BIT = 1;
  localparam int SAMPLE_CONV_LSB = 2;
  localparam int SAMPLE_IDX_LSB = 4;
  localparam int CTR_LANE_LSB = 4;
  localparam int CTR_TYPE_LSB = 0;
  localparam int ILAS_TEST_BIT = 7;
  localparam int LINK_ON_BIT = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [23:0] PRBS_LIMIT_RST = 24'hffffff;
  localparam logic [7:0] ERR_LIMIT_RST = 8'hff;
  localparam logic [7:0] LANE_ENABLE_RST = 8'hff;

  // ----------------------------------------------------------------------
  // Encodings and counts
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SLTM_PRBS7 = 2'h0,
    SLTM_PRBS15 = 2'h1,
    SLTM_PRBS31 = 2'h2
  } sltm_prbs_t;

  localparam logic [1:0] CTR_DISPARITY = 2'h0;
  localparam logic [1:0] CTR_NOT_IN_TABLE = 2'h1;
  localparam logic [1:0] CTR_UNEXPECTED_K = 2'h2;

  localparam logic [7:0] CHAR_K28_5 = 8'hbc;
  localparam logic [7:0] CHAR_K28_0 = 8'h1c;
  localparam logic [7:0] CHAR_K28_3 = 8'h7c;
  localparam logic [7:0] CHAR_K28_7 = 8'hfc;

  localparam logic [2:0] CGS_CHARS_NEEDED = 3'h4;
  localparam logic [2:0] REINIT_DISP_ERRORS = 3'h4;
  localparam logic [4:0] PRBS_FILL_BITS = 5'h1f;

  // ----------------------------------------------------------------------
  // Transmitter side
  // ----------------------------------------------------------------------
  localparam logic [11:0] HREG_CONTROL = 12'h000;
  localparam logic [11:0] HREG_STATUS = 12'h001;
  localparam int H_MODE_LSB = 0;
  localparam int H_PAT_LSB = 2;
  localparam int H_ILAS_REPEAT_BIT = 4;
  localparam int H_SAMPLE_GEN_BIT = 5;
  localparam int H_DISP_ERR_BIT = 6;
  localparam logic [1:0] H_MODE_PRBS = 2'h1;
  localparam logic [1:0] H_MODE_LINK = 2'h2;
  localparam logic [15:0] SAMPLE_BASE = 16'h5a00;
  localparam logic [1:0] ILAS_LAST = 2'h3;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_CGS = 2'h1,
    HS_ILAS = 2'h3,
    HS_DATA = 2'h2
  } sltm_hstate_t;

endpackage

// >>> hdl/sltm_link_if.sv
// Link between the transmitter and the receive-side test monitor.
`timescale 1ns/1ps
interface sltm_link_if;
  logic [sltm_pkg::NUM_LANES-1:0] rawBit;
  logic [sltm_pkg::NUM_LANES-1:0][7:0] charData;
  logic [sltm_pkg::NUM_LANES-1:0] charIsK;
  logic [sltm_pkg::NUM_LANES-1:0] dispErr;
  logic [sltm_pkg::NUM_LANES-1:0] notInTable;
  logic sampleValid;
  logic [1:0] sampleConv;
  logic [1:0] sampleIdx;
  logic [15:0] sampleData;
  logic syncRequestOut;

  modport device (
    input rawBit, charData, charIsK, dispErr, notInTable,
    input sampleValid, sampleConv, sampleIdx, sampleData,
    output syncRequestOut
  );
  modport host (
    output rawBit, charData, charIsK, dispErr, notInTable,
    output sampleValid, sampleConv, sampleIdx, sampleData,
    input syncRequestOut
  );
endinterface

// >>> hdl/sltm_host.sv
// Link transmitter: PRBS source, CGS/ILAS sequencer and sample generator.
`timescale 1ns/1ps
module sltm_host (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [sltm_pkg::WB_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Link
  sltm_link_if.host link
);

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic [7:0] ctl;
    sltm_pkg::sltm_hstate_t state;
    logic syncSeen;
    logic [30:0] lfsr;
    logic [1:0] ilasPos;
    logic [7:0] txChar;
    logic txK;
    logic [7:0] dataByte;
    logic sampleValid;
    logic [3:0] sampleSel;
    logic [15:0] sampleData;
  } sltm_host_state_t;

  sltm_host_state_t s, n;
  logic [11:0] idx;
  logic nb;

  assign idx = adr_i[13:2];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    n = s;
    n.ack = 1'b0;
    if (cyc_i && stb_i && !s.ack)
    begin
      n.ack = 1'b1;
      n.rdata = 8'h00;
      if (idx == sltm_pkg::HREG_CONTROL)
        n.rdata = s.ctl;
      else if (idx == sltm_pkg::HREG_STATUS)
        n.rdata = {6'h00, s.state == sltm_pkg::HS_DATA, link.syncRequestOut};
    end
    if (cyc_i && stb_i && s.ack && we_i && sel_i[0]
        && idx == sltm_pkg::HREG_CONTROL)
      n.ctl = dat_i[7:0];

    // Same tap positions as the checker, so history index 0 is newest.
    unique case (s.ctl[sltm_pkg::H_PAT_LSB +: 2])
      sltm_pkg::SLTM_PRBS15: nb = s.lfsr[13] ^ s.lfsr[14];
      sltm_pkg::SLTM_PRBS31: nb = s.lfsr[27] ^ s.lfsr[30];
      default: nb = s.lfsr[5] ^ s.lfsr[6];
    endcase
    if (s.ctl[sltm_pkg::H_MODE_LSB +: 2] == sltm_pkg::H_MODE_PRBS)
      n.lfsr = {s.lfsr[29:0], nb};

    n.txK = 1'b0;
    n.txChar = 8'h00;
    if (s.ctl[sltm_pkg::H_MODE_LSB +: 2] != sltm_pkg::H_MODE_LINK)
    begin
      n.state = sltm_pkg::HS_IDLE;
      n.syncSeen = 1'b0;
    end
    else if (link.syncRequestOut)
    begin
      n.state = sltm_pkg::HS_CGS;
      n.syncSeen = 1'b1;
      n.txK = 1'b1;
      n.txChar = sltm_pkg::CHAR_K28_5;
    end
    else
    begin
      unique case (s.state)
        sltm_pkg::HS_IDLE:
        begin
          n.state = sltm_pkg::HS_CGS;
          n.txK = 1'b1;
          n.txChar = sltm_pkg::CHAR_K28_5;
        end
        sltm_pkg::HS_CGS:
        begin
          // Wait for a request to come and go before leaving CGS.
          n.txK = 1'b1;
          n.txChar = sltm_pkg::CHAR_K28_5;
          n.ilasPos = 2'h0;
          if (s.syncSeen)
            n.state = sltm_pkg::HS_ILAS;
        end
        sltm_pkg::HS_ILAS:
        begin
          n.ilasPos = s.ilasPos + 2'h1;
          n.txK = (s.ilasPos == 2'h0) || (s.ilasPos == sltm_pkg::ILAS_LAST);
          if (s.ilasPos == 2'h0)
            n.txChar = sltm_pkg::CHAR_K28_0;
          else if (s.ilasPos == sltm_pkg::ILAS_LAST)
          begin
            n.txChar = sltm_pkg::CHAR_K28_3;
            if (!s.ctl[sltm_pkg::H_ILAS_REPEAT_BIT]) // RULE16
              n.state = sltm_pkg::HS_DATA;
          end
        end
        sltm_pkg::HS_DATA:
        begin
          n.dataByte = s.dataByte + 8'h01;
          n.txChar = s.dataByte;
        end
      endcase
    end

    // Every converter/sample pair gets its own value, repeated forever.
    n.sampleValid = s.ctl[sltm_pkg::H_SAMPLE_GEN_BIT]; // RULE13 RULE14
    if (s.ctl[sltm_pkg::H_SAMPLE_GEN_BIT])
    begin
      n.sampleSel = s.sampleSel + 4'h1;
      n.sampleData = sltm_pkg::SAMPLE_BASE + {12'h000, n.sampleSel}; // RULE13
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.lfsr <= 31'h7fffffff;
    end
    else
      s <= n;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign dat_o = {24'h000000, s.rdata};
  assign ack_o = s.ack;
  assign link.rawBit = {sltm_pkg::NUM_LANES{s.lfsr[0]}};
  assign link.charData = {sltm_pkg::NUM_LANES{s.txChar}};
  assign link.charIsK = {sltm_pkg::NUM_LANES{s.txK}};
  assign link.dispErr = {7'h00, s.ctl[sltm_pkg::H_DISP_ERR_BIT]};
  assign link.notInTable = '0;
  assign link.sampleValid = s.sampleValid;
  assign link.sampleConv = s.sampleSel[3:2];
  assign link.sampleIdx = s.sampleSel[1:0];
  assign link.sampleData = s.sampleData;

endmodule // sltm_host

// >>> hdl/sltm_device.sv
// Receive-side link test monitor: PRBS, sample, CGS/ILAS and 8b/10b errors.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps

// How it works
// RULE1: Pattern pick selects PRBS7, PRBS15 or PRBS31.
// RULE2: Checker uses raw lane bits, no link state.
// RULE3: One enable bit per physical lane.
// RULE4: Clear pulse wipes checker, counts, pass flags.
// RULE5: Run rising edge starts; zero stops checking.
// RULE6: Lane fails once count reaches 24-bit limit.
// RULE7: Pass byte, one bit per lane.
// RULE8: Lane pick routes saturating 24-bit count.
// RULE9: Converter and index pick choose compared sample.
// RULE10: Expected 16-bit sample compared with received.
// RULE11: Sample test runs when enabled; clear resets.
// RULE12: Result bit set on any mismatch.
// RULE13: Transmitter sends unique repeating sample values.
// RULE14: Transmitter syncs link, enables its generator.
// RULE15: Code-group sync pass per lane, link-picked.
// RULE16: Four K28.5 per lane releases sync request.
// RULE17: Lane init sync pass per lane, link-picked.
// RULE18: Disparity counter counts bad-disparity characters up to the error threshold; the resync at four errors clears it, so it never passes 4.
// RULE19: Counter pick written, selected count read back.
// RULE20: Type 0 disparity, 1 not-in-table, 2 control.
// RULE21: Second link maps lane x to x+4.
// RULE22: Error counters stop at error threshold.
// RULE23: Four disparity errors force resync request.
// RULE24: PRBS results update only while running.
module sltm_device #(
  parameter int NUM_LANES = sltm_pkg::NUM_LANES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [sltm_pkg::WB_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Link
  sltm_link_if.device link
);

  // Every status register is one byte wide, one bit per lane.
  if (NUM_LANES != 8)
  begin : g_lane_check
    $error("sltm_device supports exactly 8 lanes");
  end

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic [7:0] linkSel;
    logic [7:0] laneEn;
    logic [7:0] prbsCtl;
    logic [23:0] prbsLimit;
    logic [7:0] sampleCtl;
    logic [15:0] expSample;
    logic [7:0] ctrPick;
    logic [7:0] testOpts;
    logic [7:0] errLimit;
    logic [7:0] laneOn;
    logic [7:0] linkOn;
    logic prbsRunning;
    logic prbsRunPrev;
    logic [7:0] prbsFail;
    logic [7:0][30:0] hist;
    logic [7:0][4:0] fill;
    logic [7:0][23:0] prbsCnt;
    logic sampleFail;
    logic [7:0][2:0] kRun;
    logic [7:0] cgsOk;
    logic [7:0] ilasSeen;
    logic [7:0] ilasOk;
    logic [7:0][2:0] dispRun;
    logic [7:0][2:0][7:0] errCnt;
    logic syncReq;
  } sltm_dev_state_t;

  sltm_dev_state_t s, n;
  logic [11:0] idx;
  logic [2:0] ctrLane;
  logic [1:0] ctrType;
  logic [2:0] prbsLane;
  logic [7:0] rd;
  logic pred;
  logic [2:0] ev;
  logic reinit;

  assign idx = adr_i[13:2];
  assign prbsLane = s.prbsCtl[sltm_pkg::PRBS_LANE_LSB +: 3];
  assign ctrType = s.ctrPick[sltm_pkg::CTR_TYPE_LSB +: 2];
  assign ctrLane = s.ctrPick[sltm_pkg::CTR_LANE_LSB +: 3]
    + (s.linkSel[sltm_pkg::LINK_SEL_BIT] ? 3'h4 : 3'h0); // RULE21

  function automatic logic [7:0] pickLink(input logic [7:0] flags,
                                           input logic second);
    pickLink = second ? {4'h0, flags[7:4]} : flags; // RULE21
  endfunction

  // ----------------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------------
  always_comb
  begin
    rd = 8'h00;
    unique case (idx)
      sltm_pkg::REG_LINK_SELECT: rd = s.linkSel;
      sltm_pkg::REG_LANE_PRBS_ENABLE: rd = s.laneEn;
      sltm_pkg::REG_PRBS_TEST_CONTROL: rd = s.prbsCtl;
      sltm_pkg::REG_PRBS_THRESHOLD_LOW: rd = s.prbsLimit[7:0];
      sltm_pkg::REG_PRBS_THRESHOLD_MID: rd = s.prbsLimit[15:8];
      sltm_pkg::REG_PRBS_THRESHOLD_HIGH: rd = s.prbsLimit[23:16];
      sltm_pkg::REG_PRBS_ERROR_COUNT_LOW: rd = s.prbsCnt[prbsLane][7:0]; // RULE8
      sltm_pkg::REG_PRBS_ERROR_COUNT_MID: rd = s.prbsCnt[prbsLane][15:8];
      sltm_pkg::REG_PRBS_ERROR_COUNT_HIGH: rd = s.prbsCnt[prbsLane][23:16];
      sltm_pkg::REG_LANE_PRBS_PASS: rd = ~s.prbsFail; // RULE7
      sltm_pkg::REG_SAMPLE_TEST_CONTROL: rd = s.sampleCtl;
      sltm_pkg::REG_EXPECTED_SAMPLE_LOW: rd = s.expSample[7:0];
      sltm_pkg::REG_EXPECTED_SAMPLE_HIGH: rd = s.expSample[15:8];
      sltm_pkg::REG_SAMPLE_TEST_RESULT: rd = {7'h00, s.sampleFail}; // RULE12
      sltm_pkg::REG_ERROR_COUNTER:
        if (ctrType != 2'h3)
          rd = s.errCnt[ctrLane][ctrType]; // RULE19 RULE20
      sltm_pkg::REG_CODE_GROUP_SYNC_STATUS:
        rd = pickLink(s.cgsOk, s.linkSel[sltm_pkg::LINK_SEL_BIT]); // RULE15
      sltm_pkg::REG_LANE_INIT_SYNC_STATUS:
        rd = pickLink(s.ilasOk, s.linkSel[sltm_pkg::LINK_SEL_BIT]); // RULE17
      sltm_pkg::REG_LINK_TEST_OPTIONS: rd = s.testOpts;
      sltm_pkg::REG_ERROR_THRESHOLD: rd = s.errLimit;
      sltm_pkg::REG_LANE_ENABLE: rd = s.laneOn;
      sltm_pkg::REG_LINK_ENABLE: rd = s.linkOn;
      default: rd = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    n = s;
    n.ack = 1'b0;
    pred = 1'b0;
    ev = 3'h0;
    if (cyc_i && stb_i && !s.ack)
    begin
      n.ack = 1'b1;
      n.rdata = rd;
    end
    // A write lands on the edge at which the master sees ack.
    if (cyc_i && stb_i && s.ack && we_i && sel_i[0])
    begin
      unique case (idx)
        sltm_pkg::REG_LINK_SELECT: n.linkSel = dat_i[7:0];
        sltm_pkg::REG_LANE_PRBS_ENABLE: n.laneEn = dat_i[7:0];
        sltm_pkg::REG_PRBS_TEST_CONTROL: n.prbsCtl = dat_i[7:0];
        sltm_pkg::REG_PRBS_THRESHOLD_LOW: n.prbsLimit[7:0] = dat_i[7:0];
        sltm_pkg::REG_PRBS_THRESHOLD_MID: n.prbsLimit[15:8] = dat_i[7:0];
        sltm_pkg::REG_PRBS_THRESHOLD_HIGH: n.prbsLimit[23:16] = dat_i[7:0];
        sltm_pkg::REG_SAMPLE_TEST_CONTROL: n.sampleCtl = dat_i[7:0];
        sltm_pkg::REG_EXPECTED_SAMPLE_LOW: n.expSample[7:0] = dat_i[7:0];
        sltm_pkg::REG_EXPECTED_SAMPLE_HIGH: n.expSample[15:8] = dat_i[7:0];
        sltm_pkg::REG_ERROR_COUNTER: n.ctrPick = dat_i[7:0]; // RULE19
        sltm_pkg::REG_LINK_TEST_OPTIONS: n.testOpts = dat_i[7:0];
        sltm_pkg::REG_ERROR_THRESHOLD: n.errLimit = dat_i[7:0];
        sltm_pkg::REG_LANE_ENABLE: n.laneOn = dat_i[7:0];
        sltm_pkg::REG_LINK_ENABLE: n.linkOn = dat_i[7:0];
        default: ;
      endcase
    end

    // PRBS run control.
    n.prbsRunPrev = s.prbsCtl[sltm_pkg::PRBS_RUN_BIT];
    if (!s.prbsCtl[sltm_pkg::PRBS_RUN_BIT])
      n.prbsRunning = 1'b0; // RULE5
    else if (!s.prbsRunPrev)
      n.prbsRunning = 1'b1; // RULE5

    // Self-synchronising checkers: the history is loaded from the line.
    for (int i = 0; i < NUM_LANES; i++)
    begin
      unique case (s.prbsCtl[sltm_pkg::PRBS_PAT_LSB +: 2]) // RULE1
        sltm_pkg::SLTM_PRBS15: pred = s.hist[i][13] ^ s.hist[i][14];
        sltm_pkg::SLTM_PRBS31: pred = s.hist[i][27] ^ s.hist[i][30];
        default: pred = s.hist[i][5] ^ s.hist[i][6];
      endcase
      if (s.prbsCtl[sltm_pkg::PRBS_CLEAR_BIT])
      begin
        n.hist[i] = '0; // RULE4
        n.fill[i] = 5'h00;
        n.prbsCnt[i] = 24'h000000;
        n.prbsFail[i] = 1'b0;
      end
      else if (s.prbsRunning && s.laneEn[i]) // RULE3 RULE24
      begin
        n.hist[i] = {s.hist[i][29:0], link.rawBit[i]}; // RULE2
        if (s.fill[i] != sltm_pkg::PRBS_FILL_BITS)
          n.fill[i] = s.fill[i] + 5'h01;
        else if (link.rawBit[i] != pred && s.prbsCnt[i] != 24'hffffff)
          n.prbsCnt[i] = s.prbsCnt[i] + 24'h000001; // RULE8
        if (n.prbsCnt[i] >= s.prbsLimit)
          n.prbsFail[i] = 1'b1; // RULE6
      end
    end

    // Short sample test.
    if (s.sampleCtl[sltm_pkg::SAMPLE_CLEAR_BIT])
      n.sampleFail = 1'b0; // RULE11
    else if (s.sampleCtl[sltm_pkg::SAMPLE_EN_BIT] && link.sampleValid // RULE11
      && link.sampleConv == s.sampleCtl[sltm_pkg::SAMPLE_CONV_LSB +: 2] // RULE9
      && link.sampleIdx == s.sampleCtl[sltm_pkg::SAMPLE_IDX_LSB +: 2]
      && link.sampleData != s.expSample) // RULE10
      n.sampleFail = 1'b1; // RULE12

    // Link establishment and error counting.
    reinit = 1'b0;
    for (int i = 0; i < NUM_LANES; i++)
      if (s.dispRun[i] == sltm_pkg::REINIT_DISP_ERRORS)
        reinit = 1'b1; // RULE23
    for (int i = 0; i < NUM_LANES; i++)
    begin
      ev[0] = link.dispErr[i]; // RULE18
      ev[1] = link.notInTable[i];
      ev[2] = link.charIsK[i] && s.ilasOk[i]
        && !s.testOpts[sltm_pkg::ILAS_TEST_BIT]
        && link.charData[i] != sltm_pkg::CHAR_K28_3
        && link.charData[i] != sltm_pkg::CHAR_K28_7;
      if (!s.linkOn[sltm_pkg::LINK_ON_BIT] || !s.laneOn[i] || reinit)
      begin
        n.kRun[i] = 3'h0;
        n.cgsOk[i] = 1'b0;
        n.ilasSeen[i] = 1'b0;
        n.ilasOk[i] = 1'b0;
        n.dispRun[i] = 3'h0;
        n.errCnt[i] = '0;
      end
      else
      begin
        if (!s.cgsOk[i])
        begin
          if (link.charIsK[i] && link.charData[i] == sltm_pkg::CHAR_K28_5)
            n.kRun[i] = s.kRun[i] + 3'h1;
          else
            n.kRun[i] = 3'h0;
          if (n.kRun[i] == sltm_pkg::CGS_CHARS_NEEDED)
            n.cgsOk[i] = 1'b1; // RULE16
        end
        else if (!s.syncReq && link.charIsK[i])
        begin
          if (link.charData[i] == sltm_pkg::CHAR_K28_0)
            n.ilasSeen[i] = 1'b1;
          if (link.charData[i] == sltm_pkg::CHAR_K28_3 && s.ilasSeen[i])
            n.ilasOk[i] = 1'b1; // RULE17
        end
        if (ev[0] && s.dispRun[i] != sltm_pkg::REINIT_DISP_ERRORS)
          n.dispRun[i] = s.dispRun[i] + 3'h1; // RULE23
        for (int t = 0; t < 3; t++)
          if (ev[t] && s.errCnt[i][t] < s.errLimit)
            n.errCnt[i][t] = s.errCnt[i][t] + 8'h01; // RULE19 RULE22
      end
    end
    n.syncReq = s.linkOn[sltm_pkg::LINK_ON_BIT]
      && (reinit || ((s.laneOn & ~n.cgsOk) != 8'h00)); // RULE16 RULE23
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.prbsLimit <= sltm_pkg::PRBS_LIMIT_RST;
      s.errLimit <= sltm_pkg::ERR_LIMIT_RST;
      s.laneOn <= sltm_pkg::LANE_ENABLE_RST;
    end
    else
      s <= n;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign dat_o = {24'h000000, s.rdata};
  assign ack_o = s.ack;
  assign link.syncRequestOut = s.syncReq;

endmodule // sltm_device

// >>> verification/sltm_link_chk.sv
// Concurrent checks on the link between transmitter and monitor.
`timescale 1ns/1ps
module sltm_link_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link
  input wire logic [7:0] rawBit,
  input wire logic [7:0][7:0] charData,
  input wire logic [7:0] charIsK,
  input wire logic [7:0] dispErr,
  input wire logic sampleValid,
  input wire logic [1:0] sampleConv,
  input wire logic [1:0] sampleIdx,
  input wire logic [15:0] sampleData,
  input wire logic syncRequestOut
);
  logic [2:0] kRun_r;
  logic [2:0] dCnt_r;
  logic k5;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  assign k5 = charIsK[0] && charData[0] == sltm_pkg::CHAR_K28_5;
  // Runs are counted here so the release can be tied to the char count.
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      kRun_r <= 3'h0;
      dCnt_r <= 3'h0;
    end
    else
    begin
      kRun_r <= !k5 ? 3'h0 : kRun_r + {2'h0, kRun_r != 3'h7};
      dCnt_r <= syncRequestOut ? 3'h0 : dCnt_r + {2'h0, dispErr[0]};
    end
  property p_same_bit;
    rawBit == 8'h00 || rawBit == 8'hff;
  endproperty
  a_same_bit: assert property (p_same_bit)
    else $error("lane bits differ");
  property p_sample_val;
    sampleValid |-> sampleData ==
      sltm_pkg::SAMPLE_BASE + {12'h000, sampleConv, sampleIdx};
  endproperty
  a_sample_val: assert property (p_sample_val)
    else $error("sample value wrong");
  property p_sample_step;
    sampleValid && $past(sampleValid) |-> {sampleConv, sampleIdx} ==
      {$past(sampleConv), $past(sampleIdx)} + 4'h1;
  endproperty
  a_sample_step: assert property (p_sample_step)
    else $error("sample order wrong");
  property p_cgs_count;
    $fell(syncRequestOut) && $past(syncRequestOut, 2) |-> kRun_r >= 3'h4;
  endproperty
  a_cgs_count: assert property (p_cgs_count)
    else $error("released before four chars");
  property p_ilas_start;
    $fell(syncRequestOut) && $past(syncRequestOut, 2) |->
      ##[1:3] charIsK[0] && charData[0] == sltm_pkg::CHAR_K28_0;
  endproperty
  a_ilas_start: assert property (p_ilas_start)
    else $error("no lane alignment after release");
  property p_ilas_order;
    charIsK[0] && charData[0] == sltm_pkg::CHAR_K28_0 |=>
      charData[0] == 8'h00 ##1 charData[0] == 8'h00
      ##1 charIsK[0] && charData[0] == sltm_pkg::CHAR_K28_3;
  endproperty
  a_ilas_order: assert property (p_ilas_order)
    else $error("alignment sequence wrong");
  property p_cgs_chars;
    syncRequestOut && $past(syncRequestOut) && $past(syncRequestOut, 2)
      |-> k5;
  endproperty
  a_cgs_chars: assert property (p_cgs_chars)
    else $error("no sync chars under request");
  property p_reinit;
    dCnt_r == 3'h4 |-> ##[0:3] syncRequestOut;
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("no resync after disparity errors");
  c_release: cover property ($fell(syncRequestOut));
  c_reinit: cover property (dCnt_r == 3'h4);
  c_sample: cover property (sampleValid);
endmodule // sltm_link_chk

// >>> verification/tb_serdes_link_test_monitor.sv
// Self-checking bench for the link test monitor and its transmitter.
`timescale 1ns/1ps
module tb_serdes_link_test_monitor;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic toDev = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [13:0] adr = 14'h0000;
  logic [31:0] wDat = 32'h00000000;
  logic [31:0] dDat, hDat;
  logic dAck, hAck;
  logic ack;
  logic [7:0] rd, c;
  logic [15:0] ev;
  logic [31:0] seed = 32'h01ad951b;
  int failures = 0;
  int checked = 0;
  assign ack = toDev ? dAck : hAck;
  always #5 clk = ~clk;
  sltm_link_if sltm_link_if_inst ();
  sltm_device sltm_device_inst (.clk(clk), .sys_rst(sys_rst),
    .cyc_i(cyc & toDev), .stb_i(stb & toDev), .we_i(we), .adr_i(adr),
    .sel_i(4'h1), .dat_i(wDat), .dat_o(dDat), .ack_o(dAck),
    .link(sltm_link_if_inst.device));
  sltm_host sltm_host_inst (.clk(clk), .sys_rst(sys_rst),
    .cyc_i(cyc & ~toDev), .stb_i(stb & ~toDev), .we_i(we), .adr_i(adr),
    .sel_i(4'h1), .dat_i(wDat), .dat_o(hDat), .ack_o(hAck),
    .link(sltm_link_if_inst.host));
  sltm_link_chk sltm_link_chk_inst (.clk(clk), .sys_rst(sys_rst),
    .rawBit(sltm_link_if_inst.rawBit), .charIsK(sltm_link_if_inst.charIsK),
    .charData(sltm_link_if_inst.charData),
    .dispErr(sltm_link_if_inst.dispErr),
    .sampleValid(sltm_link_if_inst.sampleValid),
    .sampleConv(sltm_link_if_inst.sampleConv),
    .sampleIdx(sltm_link_if_inst.sampleIdx),
    .sampleData(sltm_link_if_inst.sampleData),
    .syncRequestOut(sltm_link_if_inst.syncRequestOut));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic report_and_stop;
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic d, input logic w, input logic [11:0] a,
    input logic [7:0] v);
    int n;
    toDev <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    wDat <= {24'h000000, v};
    @(posedge clk);
    for (n = 0; n < 40 && ack !== 1'b1; n++) @(posedge clk);
    failures += (n >= 40);
    rd = d ? dDat[7:0] : hDat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    wb(1'b1, 1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  task automatic prbs(input int p, input int bad);
    logic [7:0] en;
    logic [2:0] ln;
    seed = nx(seed);
    ln = seed[10:8];
    en = seed[7:0] | (8'h01 << ln);
    wb(1'b0, 1'b1, 12'h000, {4'h0, 2'((p + bad) % 3), 2'h1});
    wb(1'b1, 1'b1, 12'h315, en);
    c = {1'b0, ln, 2'(p), 2'b00};
    wb(1'b1, 1'b1, 12'h316, c | 8'h01);
    wb(1'b1, 1'b1, 12'h316, c);
    wb(1'b1, 1'b1, 12'h316, c | 8'h02);
    repeat (200) @(posedge clk);
    wb(1'b1, 1'b1, 12'h316, c);
    rc(12'h31d, bad ? ~en : 8'hff);
    wb(1'b1, 1'b0, 12'h31a, 8'h00);
    chk({7'h00, rd != 8'h00}, 8'(bad));
    rc(12'h31c, 8'h00);
  endtask
  initial
  begin
    #400000;
    failures++;
    report_and_stop;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rc(12'h47c, 8'hff);
    rc(12'h317, 8'hff);
    wb(1'b1, 1'b1, 12'h123, 8'h5a);
    rc(12'h123, 8'h00);
    wb(1'b1, 1'b1, 12'h317, 8'h05);
    wb(1'b1, 1'b1, 12'h318, 8'h00);
    wb(1'b1, 1'b1, 12'h319, 8'h00);
    for (int p = 0; p < 6; p++) prbs(p % 3, p / 3);
    wb(1'b0, 1'b1, 12'h000, 8'h22);
    wb(1'b1, 1'b1, 12'h477, 8'h80);
    wb(1'b1, 1'b1, 12'h3f0, 8'h01);
    rd = 8'h00;
    for (int n = 0; n < 60 && rd[1] !== 1'b1; n++)
      wb(1'b0, 1'b0, 12'h001, 8'h00);
    chk(rd & 8'h03, 8'h02);
    for (int s = 0; s < 2; s++)
    begin
      wb(1'b1, 1'b1, 12'h300, s ? 8'h04 : 8'h00);
      wb(1'b1, 1'b0, 12'h470, 8'h00);
      chk(rd & 8'h0f, 8'h0f);
      wb(1'b1, 1'b0, 12'h473, 8'h00);
      chk(rd & 8'h0f, 8'h0f);
    end
    for (int k = 0; k < 16; k++)
    begin
      seed = nx(seed);
      ev = (16'h5a00 + 16'(k)) ^ {15'h0000, seed[0]};
      c = {2'b00, 2'(k), 2'(k >> 2), 2'b01};
      wb(1'b1, 1'b1, 12'h32d, ev[7:0]);
      wb(1'b1, 1'b1, 12'h32e, ev[15:8]);
      wb(1'b1, 1'b1, 12'h32c, c | 8'h02);
      wb(1'b1, 1'b1, 12'h32c, c);
      repeat (20) @(posedge clk);
      rc(12'h32f, {7'h00, seed[0]});
    end
    wb(1'b1, 1'b1, 12'h300, 8'h00);
    wb(1'b1, 1'b1, 12'h47c, 8'h02);
    wb(1'b0, 1'b1, 12'h000, 8'h62);
    repeat (3) @(posedge clk);
    wb(1'b0, 1'b1, 12'h000, 8'h22);
    repeat (100) @(posedge clk);
    wb(1'b1, 1'b1, 12'h46b, 8'h00);
    wb(1'b1, 1'b0, 12'h46b, 8'h00);
    chk({7'h00, rd <= 8'h02}, 8'h01);
    for (int t = 1; t < 4; t++)
    begin
      wb(1'b1, 1'b1, 12'h46b, 8'(t));
      rc(12'h46b, 8'h00);
    end
    report_and_stop;
  end
endmodule // tb_serdes_link_test_monitor
